/* File: src/duart_host_pkg.sv */
// shared constants and types for the dual uart host port and strap logic
package duart_host_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam int NUM_REGS = 8;
  localparam int NUM_CHAN = 2;
  localparam int FIFO_DEPTH_DEF = 64;
  // register offsets inside one channel
  localparam logic [ADDR_W-1:0] REG_DATA = 3'h0;
  localparam logic [ADDR_W-1:0] REG_FEATURE = 3'h2;
  localparam logic [ADDR_W-1:0] REG_MODEM_CTRL = 3'h4;
  localparam logic [ADDR_W-1:0] REG_EXT_STATUS = 3'h6;
  localparam logic [DATA_W-1:0] REG_RESET_VAL = 8'h00;
  // field positions
  localparam int MCR_RTS_BIT = 1;
  localparam int MCR_PRESCALE_BIT = 7;
  localparam int FEATURE_CONTROL_REG_AUTO_DIR_BIT = 3;
  localparam int EXTENDED_MODEM_STATUS_REG_DIR_INV_BIT = 3;
  // prescaler divide ratios
  localparam int PRESCALE_DIV1 = 1;
  localparam int PRESCALE_DIV4 = 4;
  localparam logic [1:0] PRESCALE_LAST = 2'(PRESCALE_DIV4 - 1);
  // reset pulse qualification
  localparam int CLK_PERIOD_PS = 5000;
  localparam int RESET_MIN_NS = 40;
  localparam int RESET_MIN_CYCLES = (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] RESET_MIN_COUNT = 4'(RESET_MIN_CYCLES);

  typedef enum logic [1:0] {BUS_IDLE, BUS_READ, BUS_WRITE} bus_state_type;

  // every pin from the host side and the straps
  typedef struct packed {
    logic reset_pin;
    logic bus_style_sel;
    logic prescaler_strap;
    logic auto_direction_strap_n;
    logic host_read_strobe_n;
    logic host_write_strobe_n;
    logic host_rw_line;
    logic chan_a_select_n;
    logic chan_b_select_n;
    logic channel_address_bit;
    logic [ADDR_W-1:0] host_addr;
    logic [DATA_W-1:0] host_data;
  } host_pins_type;

  localparam host_pins_type PINS_IDLE = '{reset_pin: 1'b0, bus_style_sel: 1'b1, prescaler_strap: 1'b1,
    auto_direction_strap_n: 1'b1, host_read_strobe_n: 1'b1, host_write_strobe_n: 1'b1, host_rw_line: 1'b1,
    chan_a_select_n: 1'b1, chan_b_select_n: 1'b1, channel_address_bit: 1'b0, host_addr: 3'h0,
    host_data: 8'h00};

  // per channel signals from the serial core, same clock
  typedef struct packed {
    logic tx_serial;
    logic tx_shift_empty;
    logic tx_pop;
    logic rx_push;
    logic [DATA_W-1:0] rx_data;
  } chan_core_type;
endpackage

/* File: src/duart_byte_fifo.sv */
// byte fifo with a registered head stage
`timescale 1ns/1ps
`default_nettype none
module duart_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] head_data,
  output logic head_valid,
  output logic full,
  output logic empty
);
  localparam int MEM_DEPTH = DEPTH - 1;
  localparam int PTR_W = $clog2(MEM_DEPTH);
  localparam int CNT_W = $clog2(DEPTH);
  localparam logic [CNT_W-1:0] MEM_FULL = CNT_W'(MEM_DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(MEM_DEPTH - 1);

  logic [WIDTH-1:0] mem [0:MEM_DEPTH-1];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic do_push;
  logic do_load;

  // the head stage plus the array give exactly DEPTH entries
  assign full = (count == MEM_FULL);
  assign empty = !head_valid && (count == '0);
  assign do_push = push && !full;
  assign do_load = (count != '0) && (!head_valid || pop);

  always_ff @(posedge clk_sys)
  begin
    if (do_push)
    begin
      mem[wr_ptr] <= push_data;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (do_load)
      begin
        rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + CNT_W'(do_push) - CNT_W'(do_load);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      head_valid <= 1'b0;
      head_data <= '0;
    end
    else if (do_load)
    begin
      head_valid <= 1'b1;
      head_data <= mem[rd_ptr];
    end
    else if (pop)
    begin
      head_valid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: src/duart_host_port.sv */
// host port, straps, reset and rs-485 direction control of the dual uart
`timescale 1ns/1ps
`default_nettype none
module duart_host_port #(
  parameter int FIFO_DEPTH = duart_host_pkg::FIFO_DEPTH_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire duart_host_pkg::host_pins_type host_pins,
  input wire logic [duart_host_pkg::NUM_CHAN-1:0] rx_pin,
  input wire duart_host_pkg::chan_core_type [duart_host_pkg::NUM_CHAN-1:0] chan_core,
  output logic [duart_host_pkg::DATA_W-1:0] host_data_out,
  output logic host_data_oe_n,
  output logic device_in_reset,
  output logic [duart_host_pkg::NUM_CHAN-1:0] rts_n,
  output logic [duart_host_pkg::NUM_CHAN-1:0] tx_pin,
  output logic [duart_host_pkg::NUM_CHAN-1:0] rx_to_core,
  output logic [duart_host_pkg::NUM_CHAN-1:0] baud_tick,
  output logic [duart_host_pkg::NUM_CHAN-1:0] prescale_div4,
  output logic [duart_host_pkg::NUM_CHAN-1:0] tx_byte_valid,
  output logic [duart_host_pkg::NUM_CHAN-1:0][duart_host_pkg::DATA_W-1:0] tx_byte,
  output logic [duart_host_pkg::NUM_CHAN-1:0] rx_fifo_full
);
  import duart_host_pkg::*;

  localparam int PIN_W = $bits(host_pins_type) + NUM_CHAN;
  localparam logic [PIN_W-1:0] PIN_VEC_IDLE = {PINS_IDLE, {NUM_CHAN{1'b1}}};

  // three stage synchroniser; only stages two and three feed the filter
  logic [PIN_W-1:0] sync1;
  logic [PIN_W-1:0] sync2;
  logic [PIN_W-1:0] sync3;
  logic [PIN_W-1:0] pin_vec;
  host_pins_type pins;
  logic [NUM_CHAN-1:0] rx_sync;

  logic reset_level;
  logic [3:0] reset_count;
  logic strap_div4;

  bus_state_type bus_state;
  logic sel_any;
  logic [NUM_CHAN-1:0] sel;
  logic want_read;
  logic want_write;
  logic [NUM_CHAN-1:0] wr_sel;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [NUM_CHAN-1:0] wr_pulse;
  logic [NUM_CHAN-1:0] rd_pulse;
  logic [ADDR_W-1:0] rd_addr;
  logic [NUM_CHAN-1:0][DATA_W-1:0] rd_data;
  logic rd_chan;

  always_ff @(posedge clk_sys)
  begin
    sync1 <= {host_pins, rx_pin};
    sync2 <= sync1;
    sync3 <= sync2;
  end

  // a bit changes only once stages two and three agree
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pin_vec <= PIN_VEC_IDLE;
    end
    else
    begin
      pin_vec <= (sync2 & ~(sync2 ^ sync3)) | (pin_vec & (sync2 ^ sync3));
    end
  end

  assign pins = pin_vec[PIN_W-1:NUM_CHAN];
  assign rx_sync = pin_vec[NUM_CHAN-1:0];

  // reset pin polarity follows the bus style
  assign reset_level = pins.bus_style_sel ? pins.reset_pin : !pins.reset_pin;

  // short glitches are not taken; the pin must stay active for the minimum width
  always_ff @(posedge clk_sys)
  begin
    if (rst || !reset_level)
    begin
      reset_count <= '0;
    end
    else if (reset_count != RESET_MIN_COUNT)
    begin
      reset_count <= reset_count + 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    device_in_reset <= rst || (reset_level && reset_count == RESET_MIN_COUNT);
  end

  // strap is caught while reset is held and frozen afterwards
  always_ff @(posedge clk_sys)
  begin
    if (device_in_reset)
    begin
      strap_div4 <= !pins.prescaler_strap;
    end
  end

  // decode of the two bus styles into select, read and write
  always_comb
  begin
    sel = '0;
    want_read = 1'b0;
    want_write = 1'b0;
    if (pins.bus_style_sel)
    begin
      sel[0] = !pins.chan_a_select_n;
      sel[1] = !pins.chan_b_select_n;
      want_read = !pins.host_read_strobe_n;
      want_write = !pins.host_write_strobe_n;
    end
    else
    begin
      sel[0] = !pins.chan_a_select_n && !pins.channel_address_bit;
      sel[1] = !pins.chan_a_select_n && pins.channel_address_bit;
      want_read = !pins.chan_a_select_n && pins.host_rw_line;
      want_write = !pins.chan_a_select_n && !pins.host_rw_line;
    end
  end

  assign sel_any = |sel;

  // bus sequencer: the strobes alone pace each access, the baud clock is not involved
  always_ff @(posedge clk_sys)
  begin
    if (device_in_reset)
    begin
      bus_state <= BUS_IDLE;
      wr_pulse <= '0;
      rd_pulse <= '0;
      wr_sel <= '0;
      wr_addr <= '0;
      wr_data <= '0;
      rd_addr <= '0;
      rd_chan <= 1'b0;
    end
    else
    begin
      wr_pulse <= '0;
      rd_pulse <= '0;
      case (bus_state)
        BUS_IDLE:
        begin
          if (sel_any && want_write)
          begin
            bus_state <= BUS_WRITE;
            wr_sel <= sel;
            wr_addr <= pins.host_addr;
            wr_data <= pins.host_data;
          end
          else if (sel_any && want_read)
          begin
            bus_state <= BUS_READ;
            rd_chan <= !sel[0];
            rd_addr <= pins.host_addr;
            rd_pulse <= sel[0] ? 2'b01 : 2'b10;
          end
        end
        BUS_WRITE:
        begin
          // data is taken at the end of the strobe, when it is surely settled
          if (sel_any && want_write)
          begin
            wr_sel <= sel;
            wr_addr <= pins.host_addr;
            wr_data <= pins.host_data;
          end
          else
          begin
            wr_pulse <= wr_sel;
            bus_state <= BUS_IDLE;
          end
        end
        BUS_READ:
        begin
          if (!(sel_any && want_read))
          begin
            bus_state <= BUS_IDLE;
          end
        end
        default:
        begin
          bus_state <= BUS_IDLE;
        end
      endcase
    end
  end

  // read data is captured on the clock edge that ends the read pulse and held to the end of the strobe
  always_ff @(posedge clk_sys)
  begin
    if (device_in_reset)
    begin
      host_data_out <= '0;
      host_data_oe_n <= 1'b1;
    end
    else
    begin
      if (|rd_pulse)
      begin
        host_data_out <= rd_data[rd_chan];
      end
      host_data_oe_n <= !(bus_state == BUS_READ && sel_any && want_read);
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++)
    begin : gen_chan
      logic [DATA_W-1:0] regs [0:NUM_REGS-1];
      logic mcr_written;
      logic auto_on;
      logic sending;
      logic tx_push;
      logic tx_empty;
      logic rx_head_valid;
      logic rx_full_now;
      logic [DATA_W-1:0] rx_head;
      logic [1:0] prescale_count;
      logic div4_now;

      assign tx_push = wr_pulse[ch] && wr_addr == REG_DATA;

      // each channel owns its registers and only its own write pulse reaches them
      always_ff @(posedge clk_sys)
      begin
        if (device_in_reset)
        begin
          for (int r = 0; r < NUM_REGS; r++)
          begin
            regs[r] <= REG_RESET_VAL;
          end
          mcr_written <= 1'b0;
        end
        else if (wr_pulse[ch] && wr_addr != REG_DATA)
        begin
          regs[wr_addr] <= wr_data;
          if (wr_addr == REG_MODEM_CTRL)
          begin
            mcr_written <= 1'b1;
          end
        end
      end

      assign rd_data[ch] = (rd_addr == REG_DATA) ? rx_head : regs[rd_addr];

      duart_byte_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
      ) u_tx_fifo (
        .clk_sys(clk_sys),
        .rst(device_in_reset),
        .push(tx_push),
        .push_data(wr_data),
        .pop(chan_core[ch].tx_pop),
        .head_data(tx_byte[ch]),
        .head_valid(tx_byte_valid[ch]),
        .full(),
        .empty(tx_empty)
      );

      duart_byte_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
      ) u_rx_fifo (
        .clk_sys(clk_sys),
        .rst(device_in_reset),
        .push(chan_core[ch].rx_push),
        .push_data(chan_core[ch].rx_data),
        .pop(rd_pulse[ch] && rd_addr == REG_DATA && rx_head_valid),
        .head_data(rx_head),
        .head_valid(rx_head_valid),
        .full(rx_full_now),
        .empty()
      );

      // the strap forces direction control; the feature bit only counts with the strap high
      assign auto_on = pins.auto_direction_strap_n ? regs[REG_FEATURE][FEATURE_CONTROL_REG_AUTO_DIR_BIT] : 1'b1;

      // a new byte wins over the end-of-frame clear in the same cycle
      always_ff @(posedge clk_sys)
      begin
        if (device_in_reset)
        begin
          sending <= 1'b0;
        end
        else if (tx_push)
        begin
          sending <= 1'b1;
        end
        else if (tx_empty && chan_core[ch].tx_shift_empty)
        begin
          sending <= 1'b0;
        end
      end

      always_ff @(posedge clk_sys)
      begin
        if (device_in_reset)
        begin
          rts_n[ch] <= 1'b1;
        end
        else if (auto_on)
        begin
          rts_n[ch] <= !sending ^ regs[REG_EXT_STATUS][EXTENDED_MODEM_STATUS_REG_DIR_INV_BIT];
        end
        else
        begin
          rts_n[ch] <= !regs[REG_MODEM_CTRL][MCR_RTS_BIT];
        end
      end

      // serial pins are parked while reset is held
      always_ff @(posedge clk_sys)
      begin
        if (device_in_reset)
        begin
          tx_pin[ch] <= 1'b1;
          rx_to_core[ch] <= 1'b1;
          rx_fifo_full[ch] <= 1'b0;
        end
        else
        begin
          tx_pin[ch] <= chan_core[ch].tx_serial;
          rx_to_core[ch] <= rx_sync[ch];
          // registered so the full flag leaves the block from a flop, one cycle late
          rx_fifo_full[ch] <= rx_full_now;
        end
      end

      assign div4_now = mcr_written ? regs[REG_MODEM_CTRL][MCR_PRESCALE_BIT] : strap_div4;

      // prescaler as an enable pulse: every cycle for divide by 1, every fourth otherwise
      always_ff @(posedge clk_sys)
      begin
        if (device_in_reset)
        begin
          prescale_count <= '0;
          baud_tick[ch] <= 1'b0;
          prescale_div4[ch] <= 1'b0;
        end
        else
        begin
          prescale_div4[ch] <= div4_now;
          prescale_count <= (prescale_count == PRESCALE_LAST) ? '0 : prescale_count + 1'b1;
          baud_tick[ch] <= div4_now ? (prescale_count == PRESCALE_LAST) : 1'b1;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* File: verif/duart_host_port_monitor.sv */
// assertions on reset, prescaler, read drive and direction behaviour at the host port
`timescale 1ns/1ps
`default_nettype none
module duart_host_port_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire duart_host_pkg::host_pins_type host_pins,
  input wire duart_host_pkg::chan_core_type [duart_host_pkg::NUM_CHAN-1:0] chan_core,
  input wire logic host_data_oe_n,
  input wire logic device_in_reset,
  input wire logic [duart_host_pkg::NUM_CHAN-1:0] rts_n,
  input wire logic [duart_host_pkg::NUM_CHAN-1:0] tx_pin,
  input wire logic [duart_host_pkg::NUM_CHAN-1:0] rx_to_core,
  input wire logic [duart_host_pkg::NUM_CHAN-1:0] baud_tick,
  input wire logic [duart_host_pkg::NUM_CHAN-1:0] prescale_div4,
  input wire logic [duart_host_pkg::NUM_CHAN-1:0] tx_byte_valid
);
  import duart_host_pkg::*;
  logic rd_raw;
  logic rst_act;
  logic [3:0] rd_age;
  logic [4:0] rst_run;
  // raw pin view, so the checks include the designer's sync and filter latency
  assign rd_raw = host_pins.bus_style_sel ?
    (!host_pins.host_read_strobe_n && !(host_pins.chan_a_select_n && host_pins.chan_b_select_n)) :
    (host_pins.host_rw_line && !host_pins.chan_a_select_n);
  assign rst_act = host_pins.reset_pin == host_pins.bus_style_sel;
  always_ff @(posedge clk_sys)
  begin
    if (rst || rd_raw)
      rd_age <= 4'h0;
    else if (rd_age != 4'hf)
      rd_age <= rd_age + 4'h1;
  end
  always_ff @(posedge clk_sys)
  begin
    if (!rst_act)
      rst_run <= 5'h00;
    else if (rst_run != 5'h1f)
      rst_run <= rst_run + 5'h01;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_busy;
    (!device_in_reset && !host_pins.auto_direction_strap_n) [*8] ##0
      (tx_byte_valid[0] || !chan_core[0].tx_shift_empty) [*3];
  endsequence
  sequence s_gap;
    !baud_tick[1] [*3] ##1 (baud_tick[1] || !prescale_div4[1]);
  endsequence
  AST_TX_HIGH: assert property (device_in_reset && $past(device_in_reset) |-> tx_pin == 2'b11)
    else $error("transmit pin low during reset");
  AST_RX_IGNORED: assert property (device_in_reset && $past(device_in_reset) |-> rx_to_core == 2'b11)
    else $error("receive input passed during reset");
  AST_OUT_DEFAULT: assert property (device_in_reset && $past(device_in_reset) |->
    rts_n == 2'b11 && baud_tick == 2'b00 && host_data_oe_n)
    else $error("outputs not at default during reset");
  AST_DIV1_TICK: assert property ((!device_in_reset && !prescale_div4[1]) [*4] |-> baud_tick[1])
    else $error("divide by one missed a tick");
  AST_DIV4_GAP: assert property (prescale_div4[1] && baud_tick[1] && !device_in_reset |=> s_gap)
    else $error("divide by four tick spacing wrong");
  AST_STRAP_HELD: assert property ($changed(prescale_div4[1]) |-> device_in_reset ||
    $past(device_in_reset) || $past(device_in_reset, 2) || $past(device_in_reset, 3))
    else $error("prescaler moved outside reset");
  AST_DIR_HOLD: assert property (s_busy |-> $stable(rts_n[0]))
    else $error("direction changed while transmitter busy");
  AST_OE_BOUND: assert property (!host_data_oe_n |-> rd_age < 4'ha)
    else $error("read data driven without a read");
  AST_READ_DRIVES: assert property (rd_raw [*8] ##1 rd_raw |-> !host_data_oe_n)
    else $error("read not answered");
  AST_RESET_QUAL: assert property ($rose(device_in_reset) |-> $past(rst) || rst_run >= 5'h08)
    else $error("reset taken from a short pulse");
  AST_RESET_TAKES: assert property (rst_run == 5'h14 |-> device_in_reset)
    else $error("long reset pulse ignored");
endmodule
bind duart_host_port duart_host_port_monitor mon_u (.clk_sys(clk_sys), .rst(rst), .host_pins(host_pins),
  .chan_core(chan_core), .host_data_oe_n(host_data_oe_n), .device_in_reset(device_in_reset), .rts_n(rts_n),
  .tx_pin(tx_pin), .rx_to_core(rx_to_core), .baud_tick(baud_tick), .prescale_div4(prescale_div4),
  .tx_byte_valid(tx_byte_valid));
`default_nettype wire

/* File: verif/host_cpu_model.sv */
// host processor model driving the parallel port pins and straps
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
  input wire logic clk_sys,
  input wire logic [duart_host_pkg::DATA_W-1:0] data_in,
  input wire logic oe_n,
  output var duart_host_pkg::host_pins_type pins
);
  import duart_host_pkg::*;
  initial pins = PINS_IDLE;
  // a style change moves the reset pin to its new idle level in the same cycle
  task automatic strap(input logic style, input logic presc, input logic dir_n);
    @(negedge clk_sys);
    pins.bus_style_sel = style;
    pins.reset_pin = !style;
    pins.prescaler_strap = presc;
    pins.auto_direction_strap_n = dir_n;
    repeat (10) @(negedge clk_sys);
  endtask
  task automatic hold_reset(input logic act);
    @(negedge clk_sys);
    pins.reset_pin = act ~^ pins.bus_style_sel;
  endtask
  // chan 2 selects both channels and is only used for strobe style writes
  task automatic access(input logic rd, input int chan, input logic [2:0] addr, input logic [7:0] wd,
    output logic [7:0] q, output logic ok);
    @(negedge clk_sys);
    pins.host_addr = addr;
    pins.host_data = wd;
    pins.chan_a_select_n = pins.bus_style_sel ? chan == 1 : 1'b0;
    pins.chan_b_select_n = !pins.bus_style_sel || chan == 0;
    pins.channel_address_bit = chan == 1;
    pins.host_rw_line = rd;
    pins.host_read_strobe_n = !(rd && pins.bus_style_sel);
    pins.host_write_strobe_n = rd || !pins.bus_style_sel;
    ok = 1'b1;
    q = 8'h00;
    repeat (12) @(negedge clk_sys);
    if (rd)
    begin
      for (int n = 0; n < 30 && oe_n !== 1'b0; n++)
        @(negedge clk_sys);
      ok = oe_n === 1'b0;
      q = data_in;
    end
    pins.host_read_strobe_n = 1'b1;
    pins.host_write_strobe_n = 1'b1;
    pins.host_rw_line = 1'b1;
    pins.chan_a_select_n = 1'b1;
    pins.chan_b_select_n = 1'b1;
    repeat (10) @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench for host port selection, straps, reset and direction control
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import duart_host_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  host_pins_type host_pins;
  logic [1:0] rx_pin = 2'b11;
  chan_core_type [1:0] chan_core = '0;
  logic [7:0] host_data_out;
  logic host_data_oe_n;
  logic device_in_reset;
  logic [1:0] rts_n, tx_pin, rx_to_core, baud_tick, prescale_div4, tx_byte_valid, rx_fifo_full;
  logic [1:0][7:0] tx_byte;
  logic [1:0] rx_go = 2'b00;
  logic [7:0] rx_val = 8'h00;
  logic [7:0] tx_exp [2];
  int busy [2] = '{0, 0};
  int num_errors = 0;
  int n_compared = 0;
  initial forever #2.5 clk_sys = ~clk_sys;
  duart_host_port #(.FIFO_DEPTH(8)) dut_u (.clk_sys(clk_sys), .rst(rst), .host_pins(host_pins),
    .rx_pin(rx_pin), .chan_core(chan_core), .host_data_out(host_data_out), .host_data_oe_n(host_data_oe_n),
    .device_in_reset(device_in_reset), .rts_n(rts_n), .tx_pin(tx_pin), .rx_to_core(rx_to_core),
    .baud_tick(baud_tick), .prescale_div4(prescale_div4), .tx_byte_valid(tx_byte_valid), .tx_byte(tx_byte),
    .rx_fifo_full(rx_fifo_full));
  host_cpu_model host_u (.clk_sys(clk_sys), .data_in(host_data_out), .oe_n(host_data_oe_n), .pins(host_pins));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(input int ch, input logic [2:0] a, input logic [7:0] d);
    logic [7:0] x;
    logic y;
    host_u.access(1'b0, ch, a, d, x, y);
  endtask
  task automatic rd(input int ch, input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] x;
    logic y;
    host_u.access(1'b1, ch, a, 8'h00, x, y);
    chk({7'h00, y}, 8'h01);
    if (!y)
      results();
    chk(x, exp);
  endtask
  task automatic wait_rts(input int ch, input logic exp);
    for (int n = 0; n < 100 && rts_n[ch] !== exp; n++)
      @(negedge clk_sys);
    chk({7'h00, rts_n[ch]}, {7'h00, exp});
    if (rts_n[ch] !== exp)
      results();
  endtask
  task automatic pin_reset(input int cyc);
    host_u.hold_reset(1'b1);
    repeat (cyc) @(negedge clk_sys);
    host_u.hold_reset(1'b0);
    repeat (12) @(negedge clk_sys);
  endtask
  // serial core stand-in: pops the transmit head, then keeps the shifter busy for a character time
  always @(negedge clk_sys)
  begin
    for (int c = 0; c < 2; c++)
    begin
      chan_core[c].tx_serial = 1'b1;
      chan_core[c].tx_pop = tx_byte_valid[c] === 1'b1 && busy[c] == 0;
      if (chan_core[c].tx_pop)
      begin
        chk(tx_byte[c], tx_exp[c]);
        busy[c] = 20;
      end
      else if (busy[c] > 0)
        busy[c]--;
      chan_core[c].tx_shift_empty = busy[c] == 0;
      chan_core[c].rx_push = rx_go[c];
      chan_core[c].rx_data = rx_val;
    end
    rx_go = 2'b00;
  end
  initial
  begin
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    repeat (10) @(negedge clk_sys);
    chk({6'h00, prescale_div4}, 8'h00);
    chk({2'b00, rts_n, tx_pin, rx_to_core}, 8'h3f);
    rd(0, REG_FEATURE, REG_RESET_VAL);
    host_u.strap(1'b1, 1'b0, 1'b1);
    chk({6'h00, prescale_div4}, 8'h00);
    rx_pin = 2'b00;
    host_u.hold_reset(1'b1);
    repeat (24) @(negedge clk_sys);
    chk({device_in_reset, 1'b0, tx_pin, rx_to_core, rts_n}, 8'hbf);
    host_u.hold_reset(1'b0);
    rx_pin = 2'b11;
    repeat (12) @(negedge clk_sys);
    chk({6'h00, prescale_div4}, 8'h03);
    wr(0, REG_MODEM_CTRL, 8'h00);
    chk({6'h00, prescale_div4}, 8'h02);
    $display("test reset and prescaler done");
    for (int a = 1; a < 8; a += 2)
    begin
      wr(0, 3'(a), {5'h15, 3'(a)});
      wr(1, 3'(a), {5'h0a, 3'(a)});
    end
    wr(2, 3'h3, 8'h3c);
    for (int a = 1; a < 8; a += 2)
    begin
      rd(0, 3'(a), a == 3 ? 8'h3c : {5'h15, 3'(a)});
      rd(1, 3'(a), a == 3 ? 8'h3c : {5'h0a, 3'(a)});
    end
    $display("test strobe style selection done");
    for (int s = 0; s < 2; s++)
    begin
      host_u.strap(1'(s), 1'b1, 1'b1);
      wr(0, 3'h7, 8'h81);
      wr(1, 3'h7, 8'h7e);
      rd(0, 3'h7, 8'h81);
      rd(1, 3'h7, 8'h7e);
      pin_reset(5);
      rd(0, 3'h7, 8'h81);
      pin_reset(24);
      rd(1, 3'h7, REG_RESET_VAL);
    end
    $display("test bus styles and reset polarity done");
    host_u.strap(1'b1, 1'b1, 1'b0);
    wr(0, REG_MODEM_CTRL, 8'h02);
    chk({6'h00, rts_n}, 8'h03);
    tx_exp = '{8'h55, 8'haa};
    wr(0, REG_DATA, 8'h55);
    chk({7'h00, rts_n[0]}, 8'h00);
    wait_rts(0, 1'b1);
    wr(1, REG_DATA, 8'haa);
    chk({7'h00, rts_n[1]}, 8'h00);
    wait_rts(1, 1'b1);
    wr(0, REG_EXT_STATUS, 8'h08);
    chk({6'h00, rts_n}, 8'h02);
    host_u.strap(1'b1, 1'b1, 1'b1);
    chk({7'h00, rts_n[0]}, 8'h00);
    wr(0, REG_EXT_STATUS, 8'h00);
    wr(0, REG_FEATURE, 8'h08);
    chk({7'h00, rts_n[0]}, 8'h01);
    $display("test direction control done");
    for (int i = 0; i < 8; i++)
    begin
      rx_val = 8'(i + 8'h30);
      rx_go[0] = 1'b1;
      repeat (2) @(negedge clk_sys);
    end
    repeat (4) @(negedge clk_sys);
    chk({6'h00, rx_fifo_full}, 8'h01);
    rd(0, REG_DATA, 8'h30);
    $display("test receive fifo done");
    results();
  end
endmodule
`default_nettype wire
